// File: core/dbg_cmp_pkg.sv
// package: register map, reset values and carriers for the compare and trace readout block
package dbg_cmp_pkg;
    localparam logic [3:0] OFF_CMP_A_LOW = 4'h1;
    localparam logic [3:0] OFF_CMP_B_HIGH = 4'h2;
    localparam logic [3:0] OFF_CMP_B_LOW = 4'h3;
    localparam logic [3:0] OFF_CMP_C_HIGH = 4'h4;
    localparam logic [3:0] OFF_CMP_C_LOW = 4'h5;
    localparam logic [3:0] OFF_TRACE_HIGH = 4'h6;
    localparam logic [3:0] OFF_TRACE_LOW = 4'h7;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam logic [7:0] CMP_RESET = 8'hff;
    localparam int STATUS_EMPTY_BIT = 0;
    localparam int STATUS_FULL_BIT = 1;
    localparam int FIFO_DEPTH = 8;

    // bus cycle seen by the comparators
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } bus_cycle_s;

    // per comparator match results
    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } match_s;
endpackage

// File: core/debug_compare_trace_readout.sv
// compare registers, bus comparators and trace word readout over avalon-mm
// Functional notes
// - comparator A low byte gives required levels of address bits 7..0.
// - comparator B high byte checks address 15..8, ignored in full mode.
// - comparator B low byte checks address 7..0, or data 7..0 in full mode.
// - in full mode each B low bit requires the same data bit level.
// - comparator C holds a sixteen-bit address in high and low bytes.
// - compare bit zero requires zero, one requires one.
// - trace high readout gives word bits 15..8, zero in event-only modes.
// - trace low readout gives bits 7..0; reading it advances the fifo.
// - end-trace reset with unit enabled, begin clear, keeps register contents.
// - full mode: A compares address, B data; dual mode: both address.
// - event-only-B modes store the bus data byte instead of flow addresses.
`timescale 1ns/10ps
module debug_compare_trace_readout #(
    parameter int FIFO_WIDTH = 16,
    parameter int FIFO_DEPTH = dbg_cmp_pkg::FIFO_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [7:0] i_avs_writedata,
    output logic [7:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // links to the rest of the debug unit
    input wire logic i_full_mode,
    input wire logic i_event_only,
    input wire logic i_event_only_b,
    input wire logic i_debug_unit_enable,
    input wire logic i_trace_begin,
    input wire logic i_end_trace,
    input wire dbg_cmp_pkg::bus_cycle_s i_bus,
    input wire logic i_capture,
    input wire logic [15:0] i_flow_addr,
    output logic o_capture_ready,
    output dbg_cmp_pkg::match_s o_match
);
    logic [7:0] cmp_a_low_byte_reg;
    logic [7:0] cmp_b_high_byte_reg;
    logic [7:0] cmp_b_low_byte_reg;
    logic [7:0] cmp_c_high_byte_reg;
    logic [7:0] cmp_c_low_byte_reg;
    logic [7:0] readdata_reg;
    logic ack_reg;
    logic keep_reg = 1'b0; // power-up value; no reset may clear it
    logic wipe_reg;
    logic fifo_valid;
    logic [FIFO_WIDTH-1:0] fifo_word;
    logic [FIFO_WIDTH-1:0] capture_word;
    logic [7:0] rd_mux;
    logic [7:0] status_byte;
    dbg_cmp_pkg::match_s match_next;

    // bus decode; one wait cycle lets read data come from a flop
    wire req = i_avs_read || i_avs_write;
    wire wr_go = i_avs_write && ack_reg;
    wire rd_go = i_avs_read && ack_reg;
    wire sel_a_low = (i_avs_address == dbg_cmp_pkg::OFF_CMP_A_LOW);
    wire sel_b_high = (i_avs_address == dbg_cmp_pkg::OFF_CMP_B_HIGH);
    wire sel_b_low = (i_avs_address == dbg_cmp_pkg::OFF_CMP_B_LOW);
    wire sel_c_high = (i_avs_address == dbg_cmp_pkg::OFF_CMP_C_HIGH);
    wire sel_c_low = (i_avs_address == dbg_cmp_pkg::OFF_CMP_C_LOW);
    wire sel_t_high = (i_avs_address == dbg_cmp_pkg::OFF_TRACE_HIGH);
    wire sel_t_low = (i_avs_address == dbg_cmp_pkg::OFF_TRACE_LOW);
    wire sel_status = (i_avs_address == dbg_cmp_pkg::OFF_STATUS);
    wire pop = rd_go && sel_t_low && fifo_valid;
    assign o_avs_waitrequest = req && !ack_reg;

    // readout mux; unmapped offsets read zero
    assign status_byte = {6'h00, !o_capture_ready, !fifo_valid};
    assign rd_mux = sel_a_low ? cmp_a_low_byte_reg :
                    sel_b_high ? cmp_b_high_byte_reg :
                    sel_b_low ? cmp_b_low_byte_reg :
                    sel_c_high ? cmp_c_high_byte_reg :
                    sel_c_low ? cmp_c_low_byte_reg :
                    sel_t_high ? (fifo_valid ? fifo_word[15:8] : 8'h00) :
                    sel_t_low ? (fifo_valid ? fifo_word[7:0] : 8'h00) :
                    sel_status ? status_byte : 8'h00;
    assign o_avs_readdata = readdata_reg;

    // handshake: ack one cycle after the request appears
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
            readdata_reg <= 8'h00;
        end else begin
            ack_reg <= req && !ack_reg;
            if (i_avs_read && !ack_reg) begin
                readdata_reg <= rd_mux;
            end
        end
    end

    // an end-trace with the unit enabled and begin clear arms retention;
    // the flag must live through reset, so reset only freezes it and the
    // wipe cycle after release consumes it; a new end-trace wins over that
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            keep_reg <= keep_reg;
        end else if (i_end_trace) begin
            keep_reg <= i_debug_unit_enable && !i_trace_begin;
        end else if (wipe_reg) begin
            keep_reg <= 1'b0;
        end
    end

    // reset cannot load a flop value, so reset leaves registers alone and
    // a wipe raised by reset and held to the first edge after release restores defaults unless retained
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wipe_reg <= 1'b1;
        end else begin
            wipe_reg <= 1'b0;
        end
    end
    wire wipe = wipe_reg && !keep_reg;

    // compare registers: no async reset, contents survive an end-trace reset that armed retention
    always_ff @(posedge i_sys_clk) begin
        if (wipe) begin
            cmp_a_low_byte_reg <= dbg_cmp_pkg::CMP_RESET;
            cmp_b_high_byte_reg <= dbg_cmp_pkg::CMP_RESET;
            cmp_b_low_byte_reg <= dbg_cmp_pkg::CMP_RESET;
            cmp_c_high_byte_reg <= dbg_cmp_pkg::CMP_RESET;
            cmp_c_low_byte_reg <= dbg_cmp_pkg::CMP_RESET;
        end else if (wr_go) begin
            if (sel_a_low) begin
                cmp_a_low_byte_reg <= i_avs_writedata;
            end
            if (sel_b_high) begin
                cmp_b_high_byte_reg <= i_avs_writedata;
            end
            if (sel_b_low) begin
                cmp_b_low_byte_reg <= i_avs_writedata;
            end
            if (sel_c_high) begin
                cmp_c_high_byte_reg <= i_avs_writedata;
            end
            if (sel_c_low) begin
                cmp_c_low_byte_reg <= i_avs_writedata;
            end
        end
    end

    // comparators: exact bitwise equality, 1 needs 1 and 0 needs 0
    // A compares only the low byte here; its high byte lives elsewhere
    wire a_hit = (i_bus.addr[7:0] == cmp_a_low_byte_reg);
    wire b_addr_hit = (i_bus.addr == {cmp_b_high_byte_reg, cmp_b_low_byte_reg});
    wire b_data_hit = (i_bus.data == cmp_b_low_byte_reg);
    wire c_hit = (i_bus.addr == {cmp_c_high_byte_reg, cmp_c_low_byte_reg});
    assign match_next.a = i_bus.valid && a_hit;
    assign match_next.b = i_bus.valid && (i_full_mode ? b_data_hit : b_addr_hit);
    assign match_next.c = i_bus.valid && c_hit;

    // registered match outputs, one per bus cycle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_match <= '0;
        end else begin
            o_match <= match_next;
        end
    end

    // event-only-B stores the data byte; event-only zeroes the high byte
    assign capture_word = i_event_only_b ? {8'h00, i_bus.data} :
                          i_event_only ? {8'h00, i_flow_addr[7:0]} :
                          i_flow_addr;

    // fifo clears only on a wipe, so an end-trace reset that armed retention keeps trace words
    trace_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(1'b0),
        .i_clear(wipe),
        .i_in_valid(i_capture),
        .o_in_ready(o_capture_ready),
        .i_in_data(capture_word),
        .o_out_valid(fifo_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_word)
    );
endmodule

// File: core/trace_fifo.sv
// trace word fifo with valid/ready on both sides
`timescale 1ns/10ps
module trace_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    // honest flags from the occupancy count
    assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem_reg[rd_ptr_reg];

    // storage only, no reset needed on data
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (i_clear) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: sim/bus_cycle_model.sv
// processor bus model: one bus cycle per start pulse
`timescale 1ns/10ps
module bus_cycle_model (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_data,
    output dbg_cmp_pkg::bus_cycle_s o_bus
);
    // idle lines flip each cycle so a stale value never fakes a match
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bus <= '0;
        end else begin
            o_bus.valid <= i_start;
            o_bus.addr <= i_start ? i_addr : ~o_bus.addr;
            o_bus.data <= i_start ? i_data : ~o_bus.data;
        end
    end
endmodule

// File: sim/dbg_readout_sva.sv
// checker: bus handshake, readback and comparator results
`timescale 1ns/10ps
module dbg_readout_sva (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [7:0] i_avs_writedata,
    input wire logic [7:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_full_mode,
    input wire dbg_cmp_pkg::bus_cycle_s i_bus,
    input wire dbg_cmp_pkg::match_s o_match
);
    logic [7:0] sh_reg [1:5];
    logic [5:1] kn_reg;
    wire logic tk = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    // shadow of taken writes; forgotten on reset since retention depends on history
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            kn_reg <= '0;
        end else if (tk && i_avs_write && i_avs_address inside {[1:5]}) begin
            sh_reg[i_avs_address] <= i_avs_writedata;
            kn_reg[i_avs_address] <= 1'b1;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    AST_WAIT_RISE: assert property ($rose(i_avs_read || i_avs_write) |->
        o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("ack timing wrong");
    AST_WAIT_IDLE: assert property (!(i_avs_read || i_avs_write) |->
        !o_avs_waitrequest) else $error("waitrequest without request");
    AST_READ_CMP: assert property (tk && i_avs_read && i_avs_address inside {[1:5]}
        && kn_reg[i_avs_address] |-> o_avs_readdata == sh_reg[i_avs_address])
        else $error("compare register readback wrong");
    AST_UNMAPPED: assert property (tk && i_avs_read && i_avs_address == 4'h0
        |-> o_avs_readdata == 8'h00) else $error("unmapped read not zero");
    AST_MATCH_A: assert property (i_bus.valid && kn_reg[1] |=> o_match.a ==
        (sh_reg[1] == $past(i_bus.addr[7:0]))) else $error("comparator a wrong");
    AST_MATCH_B: assert property (i_bus.valid && kn_reg[2] && kn_reg[3] |=>
        o_match.b == ($past(i_full_mode) ? sh_reg[3] == $past(i_bus.data)
        : {sh_reg[2], sh_reg[3]} == $past(i_bus.addr))) else $error("comparator b wrong");
    AST_MATCH_C: assert property (i_bus.valid && kn_reg[4] && kn_reg[5] |=>
        o_match.c == ({sh_reg[4], sh_reg[5]} == $past(i_bus.addr)))
        else $error("comparator c wrong");
    AST_IDLE_NO_MATCH: assert property (!i_bus.valid |=> o_match == '0)
        else $error("match without bus cycle");
    cover property (i_bus.valid && i_full_mode);
    cover property (tk && i_avs_read && i_avs_address == 4'h7);
    cover property (tk && i_avs_write);
endmodule

bind debug_compare_trace_readout dbg_readout_sva dbg_readout_sva_inst (.i_sys_clk, .i_rst,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
    .o_avs_waitrequest, .i_full_mode, .i_bus, .o_match);

// File: sim/tb_debug_compare_trace_readout.sv
// self-checking bench for the compare and trace readout block
`timescale 1ns/10ps
module tb_debug_compare_trace_readout;
    logic i_sys_clk = 0, i_rst = 1, rd = 0, wr = 0, full = 0, eo = 0, eob = 0;
    logic en = 0, bgn = 0, et = 0, cap = 0, go = 0, wreq, crdy;
    logic [3:0] adr = '0;
    logic [7:0] wd = '0, bdat = '0, rdat, q;
    logic [15:0] fa = '0, badr = '0;
    dbg_cmp_pkg::bus_cycle_s bus;
    dbg_cmp_pkg::match_s mt;
    int mismatches = 0, n_checks = 0, cyc = 0;
    logic [7:0] vals [1:5] = '{8'h34, 8'h12, 8'h56, 8'hab, 8'hcd};
    // bus cycle rows: full mode, address, data, expected {a,b,c}
    logic [27:0] rows [6] = '{{1'b0, 16'h1256, 8'h00, 3'b010}, {1'b0, 16'habcd, 8'h00, 3'b001},
        {1'b0, 16'h0034, 8'h00, 3'b100}, {1'b1, 16'h0034, 8'h56, 3'b110},
        {1'b1, 16'hff34, 8'h57, 3'b100}, {1'b0, 16'habcc, 8'h56, 3'b000}};
    debug_compare_trace_readout debug_compare_trace_readout_inst (.i_sys_clk, .i_rst,
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_full_mode(full),
        .i_event_only(eo), .i_event_only_b(eob), .i_debug_unit_enable(en),
        .i_trace_begin(bgn), .i_end_trace(et), .i_bus(bus), .i_capture(cap),
        .i_flow_addr(fa), .o_capture_ready(crdy), .o_match(mt));
    bus_cycle_model bus_cycle_model_inst (.i_sys_clk, .i_rst, .i_start(go), .i_addr(badr),
        .i_data(bdat), .o_bus(bus));
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    // hang guard
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until the edge at which waitrequest is sampled low
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge i_sys_clk);
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic bcyc(input logic f, input logic [15:0] a, input logic [7:0] d, input logic c);
        @(posedge i_sys_clk);
        go <= 1'b1;
        badr <= a;
        bdat <= d;
        full <= f;
        @(posedge i_sys_clk);
        go <= 1'b0;
        cap <= c;
        @(posedge i_sys_clk);
        cap <= 1'b0;
        #1;
    endtask
    task automatic end_trace_reset(input logic keep);
        @(posedge i_sys_clk);
        en <= 1'b1;
        bgn <= !keep;
        et <= 1'b1;
        @(posedge i_sys_clk);
        et <= 1'b0;
        i_rst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        for (int k = 1; k < 6; k++) begin
            acc(0, 4'(k), 8'h00);
            cmp(q, 16'h00ff);
        end
        acc(0, 4'h0, 8'h00);
        cmp(q, 16'h0000);
        for (int k = 1; k < 6; k++) acc(1, 4'(k), vals[k]);
        acc(1, 4'h6, 8'h77);
        for (int k = 1; k < 6; k++) begin
            acc(0, 4'(k), 8'h00);
            cmp(q, 16'(vals[k]));
        end
        for (int i = 0; i < 6; i++) begin
            bcyc(rows[i][27], rows[i][26:11], rows[i][10:3], 1'b0);
            cmp(16'(mt), 16'(rows[i][2:0]));
        end
        // fill past capacity: the ninth push must be refused
        for (int i = 0; i < 9; i++) begin
            @(posedge i_sys_clk);
            cap <= 1'b1;
            fa <= 16'h1000 + 16'(i);
        end
        @(posedge i_sys_clk);
        cap <= 1'b0;
        fa <= 16'h5aa5;
        #1;
        cmp(16'(crdy), 16'h0000);
        for (int i = 0; i < 9; i++) begin
            acc(0, 4'h6, 8'h00);
            cmp(q, (i < 8) ? 16'h0010 : 16'h0000);
            acc(0, 4'h7, 8'h00);
            cmp(q, (i < 8) ? 16'(i) : 16'h0000);
        end
        eo <= 1'b1;
        bcyc(0, 16'h0000, 8'h00, 1'b1);
        acc(0, 4'h6, 8'h00);
        cmp(q, 16'h0000);
        acc(0, 4'h7, 8'h00);
        cmp(q, 16'h00a5);
        eo <= 1'b0;
        eob <= 1'b1;
        bcyc(0, 16'h0000, 8'h3c, 1'b1);
        acc(0, 4'h7, 8'h00);
        cmp(q, 16'h003c);
        end_trace_reset(1'b1);
        for (int k = 1; k < 6; k++) begin
            acc(0, 4'(k), 8'h00);
            cmp(q, 16'(vals[k]));
        end
        end_trace_reset(1'b0);
        for (int k = 1; k < 6; k++) begin
            acc(0, 4'(k), 8'h00);
            cmp(q, 16'h00ff);
        end
        end_of_test();
    end
endmodule
